// ===== shared/sap_pkg.sv
// shared constants and types for the stereo serial audio port
package sap_pkg;
  // serial word and frame layout
  localparam int SAP_WORD_BITS = 32;
  localparam int SAP_FRAME_BITS = 2 * SAP_WORD_BITS;
  localparam int SAP_FIFO_DEPTH = 32;

  // register map, byte addresses on the plain register port
  localparam int SAP_ADDR_W = 4;
  localparam logic [SAP_ADDR_W-1:0] SAP_REG_CTRL = 4'h0;
  localparam logic [SAP_ADDR_W-1:0] SAP_REG_STATUS = 4'h4;
  localparam logic [SAP_ADDR_W-1:0] SAP_REG_PERIOD = 4'h8;

  // control register fields
  localparam int SAP_CTRL_W = 3;
  localparam int SAP_CTRL_PORT_EN = 0;
  localparam int SAP_CTRL_LEFT_EN = 1;
  localparam int SAP_CTRL_RIGHT_EN = 2;
  localparam logic [SAP_CTRL_W-1:0] SAP_CTRL_RESET = 3'h7;

  // status register fields
  localparam int SAP_ST_VALID = 0;
  localparam int SAP_ST_FAM44 = 1;
  localparam int SAP_ST_RATE_LSB = 2;
  localparam int SAP_ST_RATIO_LSB = 5;
  localparam int SAP_ST_MASTER = 9;
  localparam int SAP_ST_TDM = 10;
  localparam int SAP_ST_FIFO_EMPTY = 11;

  // frame-rate measurement against the 200 MHz clock
  localparam int SAP_CLK_HZ = 200_000_000;
  localparam int SAP_PERIOD_W = 16;
  localparam int SAP_BCNT_W = 10;
  localparam int SAP_TOL_SHIFT = 6;
  localparam int SAP_NUM_RATES = 7;
  localparam int SAP_NUM_RATIOS = 11;
  localparam int SAP_RATE48_HZ [SAP_NUM_RATES] = '{8000, 16000, 24000, 32000, 48000, 96000, 192000};
  localparam int SAP_RATE44_HZ [SAP_NUM_RATES] = '{7350, 14700, 22050, 29400, 44100, 88200, 176400};
  localparam int SAP_RATIOS [SAP_NUM_RATIOS] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512};

  // table positions that carry exceptions
  localparam logic [2:0] SAP_RIDX_LOWEST = 3'h0;
  localparam logic [2:0] SAP_RIDX_SECOND = 3'h1;
  localparam logic [2:0] SAP_RIDX_MASTER = 3'h4;
  localparam logic [2:0] SAP_RIDX_DOUBLE = 3'h5;
  localparam logic [2:0] SAP_RIDX_QUAD = 3'h6;
  localparam logic [3:0] SAP_QIDX_24 = 4'h1;
  localparam logic [3:0] SAP_QIDX_32 = 4'h2;
  localparam logic [3:0] SAP_QIDX_192 = 4'h7;
  localparam logic [3:0] SAP_QIDX_384 = 4'h9;

  // master clock generation from the reference clock
  localparam logic [2:0] SAP_MCLK_HALF_256 = 3'h2;
  localparam logic [2:0] SAP_MCLK_HALF_512 = 3'h4;
  localparam logic [5:0] SAP_MASTER_HALF_FRAME = 6'h20;

  typedef struct packed {
    logic [SAP_WORD_BITS-1:0] left;
    logic [SAP_WORD_BITS-1:0] right;
  } sap_pair_s;

  typedef struct packed {
    logic valid;
    logic fam44;
    logic [2:0] rate;
    logic [3:0] ratio;
    logic [SAP_PERIOD_W-1:0] period;
  } sap_cfg_s;
endpackage

// ===== tb/sap_host_model.sv
// host side: slave clocks, captures data on bit clock rises
`timescale 1ns/10ps
`default_nettype none
module sap_host_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] half,
  input wire logic [7:0] phase_bits,
  input wire logic bit_clock_in,
  input wire logic frame_sync_in,
  input wire logic serial_data_output,
  output logic host_bclk,
  output logic host_fs,
  output logic frame_done,
  output logic [63:0] cap_left,
  output logic [63:0] cap_right
);
  logic [15:0] cnt = 16'h0000;
  logic [7:0] bitn = 8'h00;
  logic prev_b = 1'b0;
  logic last_fs = 1'b1;
  logic [63:0] shreg = 64'h0;
  logic [63:0] shreg_n;
  assign shreg_n = {shreg[62:0], serial_data_output};
  // bit clock low between runs: no stray edges
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 16'h0000;
      host_bclk <= 1'b0;
      host_fs <= 1'b1;
      bitn <= 8'h00;
    end else if (cnt == half - 16'h0001) begin
      cnt <= 16'h0000;
      host_bclk <= !host_bclk;
      if (host_bclk) begin
        bitn <= (bitn == phase_bits - 8'h01) ? 8'h00 : bitn + 8'h01;
        if (bitn == phase_bits - 8'h01) host_fs <= !host_fs;
      end
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  // a half is latched at the rise that sees frame sync moved
  always @(posedge clk) begin
    prev_b <= bit_clock_in;
    frame_done <= 1'b0;
    if (bit_clock_in && !prev_b) begin
      shreg <= shreg_n;
      last_fs <= frame_sync_in;
      if (frame_sync_in && !last_fs) cap_left <= shreg_n;
      if (!frame_sync_in && last_fs) begin
        cap_right <= shreg_n;
        frame_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/sap_i2s_port_assertions.sv
// pin-level checks on the serial audio port, bound into the top module
`timescale 1ns/10ps
`default_nettype none
module sap_i2s_port_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bit_clock_in,
  input wire logic bit_clock_out,
  input wire logic bit_clock_oe_n,
  input wire logic frame_sync_out,
  input wire logic frame_sync_oe_n,
  input wire logic serial_data_output,
  input wire logic role_select_pin,
  input wire logic pll_locked,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [6:0] rises;
  logic seen;
  logic bclk_now;
  // bit clock on the wire
  assign bclk_now = role_select_pin ? bit_clock_out : bit_clock_in;
  // bit clock rises per frame sync half; first half skipped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rises <= 7'h00;
      seen <= 1'b0;
    end else if ($changed(frame_sync_out)) begin
      rises <= 7'h00;
      seen <= 1'b1;
    end else begin
      rises <= rises + {6'h00, $rose(bit_clock_out)};
    end
  end
  a_oe_role: assert property (bit_clock_oe_n == !role_select_pin && frame_sync_oe_n == !role_select_pin)
    else $error("enables vs role");
  a_slave_quiet: assert property ((!role_select_pin) [*3] |-> !bit_clock_out && !frame_sync_out)
    else $error("clocks driven as slave");
  a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("stale read data");
  a_fs_on_rise: assert property ($changed(frame_sync_out) && role_select_pin |-> bit_clock_out)
    else $error("frame sync off rise");
  a_fs_half_len: assert property ($changed(frame_sync_out) && role_select_pin && seen |->
    rises + {6'h00, $rose(bit_clock_out)} == 7'h20)
    else $error("frame sync half length");
  a_quiet_unlocked: assert property (!pll_locked && !$past(pll_locked) |-> !serial_data_output)
    else $error("data while unlocked");
  a_sdo_on_fall: assert property ($changed(serial_data_output) && pll_locked && $past(pll_locked) |-> !bclk_now)
    else $error("data moved, clock high");
  a_lock_waits: assert property ($fell(sys_rst) |-> (!pll_locked) [*8])
    else $error("early lock");
  c_slave_lock: cover property (pll_locked && !role_select_pin);
  c_master_lock: cover property (pll_locked && role_select_pin);
  c_data_high: cover property (serial_data_output && pll_locked);
endmodule
bind sap_i2s_port sap_i2s_port_checker sap_i2s_port_checker_i (.*);
`default_nettype wire

// ===== tb/sap_i2s_port_test.sv
// self-checking bench for the serial audio port
`timescale 1ns/10ps
`default_nettype none
module sap_i2s_port_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mode_select_pin_a = 1'b0;
  logic mode_select_pin_b = 1'b0;
  logic role_select_pin = 1'b0;
  logic format_select_pin = 1'b0;
  logic sample_in_valid = 1'b0;
  sap_pkg::sap_pair_s sample_in_data = '0;
  logic [sap_pkg::SAP_ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic [15:0] half = 16'h0021;
  logic [7:0] phase_bits = 8'h20;
  logic [15:0] ref_acc = 16'h0000;
  logic [15:0] ref_step = 16'h0000;
  logic bit_clock_out, bit_clock_oe_n, frame_sync_out, frame_sync_oe_n, serial_data_output;
  logic pll_locked, sample_in_ready, host_bclk, host_fs, frame_done, bit_clock_in, frame_sync_in;
  logic [31:0] reg_rdata;
  logic [63:0] cap_left, cap_right;
  int error_cnt = 0;
  int checks_done = 0;
  // wire level: the enabled side drives
  assign bit_clock_in = bit_clock_oe_n ? host_bclk : bit_clock_out;
  assign frame_sync_in = frame_sync_oe_n ? host_fs : frame_sync_out;
  always #2.5 clk = ~clk;
  // reference clock from a phase accumulator
  always @(posedge clk) begin
    ref_acc <= ref_acc + ref_step;
    mode_select_pin_b <= ref_acc[15];
  end
  sap_i2s_port sap_i2s_port_i (.*);
  sap_host_model sap_host_model_i (.*);
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic role);
    @(posedge clk);
    run <= 1'b0;
    sys_rst <= 1'b1;
    role_select_pin <= role;
    format_select_pin <= 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic sap_pkg::sap_pair_s pair_of(input int k);
    pair_of.left = 32'h8123_4501 ^ 32'(k);
    pair_of.right = 32'hC0DE_0003 + 32'(k);
  endfunction
  task automatic push(input sap_pkg::sap_pair_s p);
    @(posedge clk);
    sample_in_valid <= 1'b1;
    sample_in_data <= p;
    for (int t = 0; t < 100; t++) begin
      @(negedge clk);
      if (sample_in_ready === 1'b1) break;
    end
    @(posedge clk);
    sample_in_valid <= 1'b0;
  endtask
  // bounded wait for host frames
  task automatic wait_frames(input int n);
    for (int k = 0; k < n; k++) begin
      for (int t = 0; t < 20000; t++) begin
        @(posedge clk);
        if (frame_done === 1'b1) break;
      end
    end
  endtask
  task automatic test_regs;
    logic [31:0] d;
    do_reset(1'b0);
    format_select_pin <= 1'b1;
    check("oe slave", 64'h3, {62'h0, bit_clock_oe_n, frame_sync_oe_n});
    reg_read(sap_pkg::SAP_REG_CTRL, d);
    check("ctrl reset", 64'h7, {32'h0, d});
    reg_write(sap_pkg::SAP_REG_STATUS, 32'hFFFF_FFFF);
    reg_read(sap_pkg::SAP_REG_STATUS, d);
    check("status idle", 64'hC00, {32'h0, d & 32'h0000_0E01});
    reg_read(4'hC, d);
    check("unmapped read", 64'h0, {32'h0, d});
    reg_write(sap_pkg::SAP_REG_CTRL, 32'h0000_0001);
    reg_read(sap_pkg::SAP_REG_CTRL, d);
    check("ctrl readback", 64'h1, {32'h0, d});
  endtask
  // fill until the buffer refuses
  task automatic test_fill;
    int n;
    logic [31:0] st;
    do_reset(1'b0);
    n = 0;
    sample_in_valid <= 1'b1;
    sample_in_data <= pair_of(7);
    for (int t = 0; t < 40; t++) begin
      @(negedge clk);
      if (sample_in_ready !== 1'b1) break;
      n++;
      @(posedge clk);
    end
    @(posedge clk);
    sample_in_valid <= 1'b0;
    check("fifo depth", 64'(sap_pkg::SAP_FIFO_DEPTH), 64'(n));
    reg_read(sap_pkg::SAP_REG_STATUS, st);
    check("empty when full", 64'h0, {63'h0, st[sap_pkg::SAP_ST_FIFO_EMPTY]});
    do_reset(1'b0);
    reg_read(sap_pkg::SAP_REG_STATUS, st);
    check("empty after reset", 64'h1, {63'h0, st[sap_pkg::SAP_ST_FIFO_EMPTY]});
  endtask
  task automatic slave_stream(input logic [15:0] hv, input logic [7:0] pb, input logic [3:0] ridx,
    input logic [2:0] ctl, input int n);
    logic [31:0] st;
    logic [63:0] mask;
    sap_pkg::sap_pair_s p;
    int w;
    do_reset(1'b0);
    reg_write(sap_pkg::SAP_REG_CTRL, {29'h0, ctl});
    half <= hv;
    phase_bits <= pb;
    run <= 1'b1;
    wait_frames(2);
    check("slave lock", 64'h1, {63'h0, pll_locked});
    reg_read(sap_pkg::SAP_REG_STATUS, st);
    check("status", 64'(1 | (4 << sap_pkg::SAP_ST_RATE_LSB) | (ridx << sap_pkg::SAP_ST_RATIO_LSB)), 64'(st[10:0]));
    for (int k = 0; k < n; k++) push(pair_of(k));
    mask = (64'h1 << pb) - 64'h1;
    w = 0;
    while (w < 5 && (cap_left & mask) === 64'h0) begin
      wait_frames(1);
      w++;
    end
    for (int k = 0; k < n; k++) begin
      p = pair_of(k);
      check("left word", 64'(p.left) << (pb - 8'h20), cap_left & mask);
      check("right word", ctl[2] ? 64'(p.right) << (pb - 8'h20) : 64'h0, cap_right & mask);
      wait_frames(1);
    end
    check("empty frame", 64'h0, (cap_left | cap_right) & mask);
    run <= 1'b0;
  endtask
  task automatic test_lock(input logic [15:0] hv, input logic [7:0] pb, input logic lk, input logic [10:0] est,
    input logic [10:0] msk);
    logic [31:0] st;
    do_reset(1'b0);
    half <= hv;
    phase_bits <= pb;
    run <= 1'b1;
    wait_frames(2);
    check("lock", 64'(lk), {63'h0, pll_locked});
    reg_read(sap_pkg::SAP_REG_STATUS, st);
    check("status detect", 64'(est), 64'(st[10:0] & msk));
    run <= 1'b0;
  endtask
  task automatic master_run(input logic pin_a, input logic [15:0] step, input logic lk);
    int n, t;
    logic f0, pb0;
    mode_select_pin_a <= pin_a;
    ref_step <= step;
    do_reset(1'b1);
    wait_frames(3);
    check("master lock", 64'(lk), {63'h0, pll_locked});
    check("oe master", 64'h0, {62'h0, bit_clock_oe_n, frame_sync_oe_n});
    f0 = frame_sync_out;
    for (t = 0; t < 3000 && frame_sync_out === f0; t++) @(posedge clk);
    #1 f0 = frame_sync_out;
    pb0 = bit_clock_out;
    n = 0;
    for (t = 0; t < 3000 && frame_sync_out === f0; t++) begin
      @(posedge clk);
      #1 if (bit_clock_out === 1'b1 && pb0 === 1'b0) n++;
      pb0 = bit_clock_out;
    end
    check("bclks per half", 64'h20, 64'(n));
  endtask
  initial begin
    test_regs;
    test_fill;
    slave_stream(16'h0021, 8'h20, 4'h4, 3'h7, 3);
    slave_stream(16'h0016, 8'h30, 4'h5, 3'h3, 1);
    test_lock(16'h0023, 8'h20, 1'b1, 11'h093, 11'h1FF);
    test_lock(16'h001A, 8'h28, 1'b0, 11'h000, 11'h001);
    master_run(1'b0, 16'h0FBA, 1'b1);
    master_run(1'b1, 16'h1F75, 1'b1);
    master_run(1'b0, 16'h1F75, 1'b0);
    final_report;
  end
  // watchdog, half again the expected run
  initial begin
    repeat (150000) @(posedge clk);
    error_cnt++;
    final_report;
  end
endmodule
`default_nettype wire

// ===== verilog/sap_fifo.sv
// sample fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sap_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;

  // extra pointer bit tells full from empty
  assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage has no reset, only pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/sap_i2s_port.sv
// stereo serial audio output port with clock generation and register port
// Function
// - left word MSB on falling bit clock, second cycle after frame sync falls.
// - right word MSB on falling bit clock, second cycle after frame sync rises.
// - in I2S every following data bit leaves on a falling bit clock edge; TDM shifts on rising edges.
// - as master, frame sync changes on the bit clock rising edge.
// - unused bit clocks of a phase carry zero on serial data.
// - slave mode sets dividers and PLL from frame rate and ratio itself.
// - 48 kHz family ratios 16 to 512 with listed exceptions.
// - 44.1 kHz family ratios 16 to 512 with listed exceptions.
// - master mode takes reference clock on mode select pin b.
// - master reference is 256 fs when pin a low, 512 fs high.
// - master mode only at 44.1 kHz and 48 kHz.
// - internal clocks come from an integrated PLL.
// - role pin low makes clocks inputs, high makes them outputs.
// - format pin low selects I2S, high selects TDM.
// - sample words are 32-bit two's complement, MSB first.
`timescale 1ns/10ps
`default_nettype none
module sap_i2s_port #(
  parameter int FIFO_DEPTH = sap_pkg::SAP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe_n,
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  output logic frame_sync_oe_n,
  output logic serial_data_output,
  input wire logic mode_select_pin_a,
  input wire logic mode_select_pin_b,
  input wire logic format_select_pin,
  input wire logic role_select_pin,
  output logic pll_locked,
  input wire logic sample_in_valid,
  output logic sample_in_ready,
  input wire sap_pkg::sap_pair_s sample_in_data,
  input wire logic [sap_pkg::SAP_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // pin modes
  logic master;
  logic tdm;
  assign master = role_select_pin;
  assign tdm = format_select_pin;

  // ---------------- master clock generation ----------------
  logic mclk_prev, next_mclk_prev;
  logic [2:0] mclk_cnt, next_mclk_cnt;
  logic bclk_int, next_bclk_int;
  logic fs_int, next_fs_int;
  logic [5:0] half_cnt, next_half_cnt;
  logic mclk_rise;
  logic [2:0] mclk_half;

  assign mclk_rise = mode_select_pin_b && !mclk_prev;
  assign mclk_half = mode_select_pin_a ? sap_pkg::SAP_MCLK_HALF_512 : sap_pkg::SAP_MCLK_HALF_256;

  // bit clock is 64 fs from the reference; frame sync every 32 bit clocks
  always_comb begin
    next_mclk_prev = mode_select_pin_b;
    next_mclk_cnt = mclk_cnt;
    next_bclk_int = bclk_int;
    next_fs_int = fs_int;
    next_half_cnt = half_cnt;
    if (!master) begin
      next_mclk_cnt = '0;
      next_bclk_int = 1'b0;
      next_fs_int = 1'b0;
      next_half_cnt = '0;
    end else if (mclk_rise) begin
      if (mclk_cnt == mclk_half - 3'h1) begin
        next_mclk_cnt = '0;
        next_bclk_int = !bclk_int;
        if (!bclk_int) begin
          // rising bit clock edge carries the frame sync change
          if (half_cnt == sap_pkg::SAP_MASTER_HALF_FRAME - 6'h01) begin
            next_half_cnt = '0;
            next_fs_int = !fs_int;
          end else begin
            next_half_cnt = half_cnt + 6'h01;
          end
        end
      end else begin
        next_mclk_cnt = mclk_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mclk_prev <= 1'b0;
      mclk_cnt <= '0;
      bclk_int <= 1'b0;
      fs_int <= 1'b0;
      half_cnt <= '0;
    end else begin
      mclk_prev <= next_mclk_prev;
      mclk_cnt <= next_mclk_cnt;
      bclk_int <= next_bclk_int;
      fs_int <= next_fs_int;
      half_cnt <= next_half_cnt;
    end
  end

  // clock pins: driven only as master, enables active low
  assign bit_clock_out = bclk_int;
  assign frame_sync_out = fs_int;
  assign bit_clock_oe_n = !master;
  assign frame_sync_oe_n = !master;

  // ---------------- effective bus clocks and rate detection ----------------
  logic bclk_cur;
  logic fs_cur;
  logic bclk_prev, next_bclk_prev;
  logic fs_seen, next_fs_seen;
  logic bclk_rise, bclk_fall;
  logic fs_edge, fs_rise_ev;
  sap_pkg::sap_cfg_s cfg;
  logic cfg_ok;

  assign bclk_cur = master ? bclk_int : bit_clock_in;
  assign fs_cur = master ? fs_int : frame_sync_in;
  assign bclk_rise = bclk_cur && !bclk_prev;
  assign bclk_fall = !bclk_cur && bclk_prev;
  // frame sync sampled on rising bit clock, old value kept in fs_seen
  assign fs_edge = bclk_rise && (fs_cur != fs_seen);
  assign fs_rise_ev = fs_edge && fs_cur;

  always_comb begin
    next_bclk_prev = bclk_cur;
    next_fs_seen = bclk_rise ? fs_cur : fs_seen;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bclk_prev <= 1'b0;
      fs_seen <= 1'b0;
    end else begin
      bclk_prev <= next_bclk_prev;
      fs_seen <= next_fs_seen;
    end
  end

  sap_rate_detect u_detect (
    .clk(clk),
    .sys_rst(sys_rst),
    .bclk_rise(bclk_rise),
    .fs_rise(fs_rise_ev),
    .cfg(cfg)
  );

  // the PLL and dividers follow the detected setup; master needs 44.1/48 only
  assign cfg_ok = master ? (cfg.valid && cfg.rate == sap_pkg::SAP_RIDX_MASTER) : cfg.valid;
  assign pll_locked = cfg_ok;

  // ---------------- register port ----------------
  logic [sap_pkg::SAP_CTRL_W-1:0] ctrl, next_ctrl;
  logic [31:0] next_reg_rdata;
  logic fifo_out_valid;
  logic port_en, left_en, right_en;

  assign port_en = ctrl[sap_pkg::SAP_CTRL_PORT_EN];
  assign left_en = ctrl[sap_pkg::SAP_CTRL_LEFT_EN];
  assign right_en = ctrl[sap_pkg::SAP_CTRL_RIGHT_EN];

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    next_ctrl = ctrl;
    next_reg_rdata = '0;
    if (reg_wr && reg_addr == sap_pkg::SAP_REG_CTRL) begin
      next_ctrl = reg_wdata[sap_pkg::SAP_CTRL_W-1:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        sap_pkg::SAP_REG_CTRL: begin
          next_reg_rdata[sap_pkg::SAP_CTRL_W-1:0] = ctrl;
        end
        sap_pkg::SAP_REG_STATUS: begin
          next_reg_rdata[sap_pkg::SAP_ST_VALID] = cfg_ok;
          next_reg_rdata[sap_pkg::SAP_ST_FAM44] = cfg.fam44;
          next_reg_rdata[sap_pkg::SAP_ST_RATE_LSB +: 3] = cfg.rate;
          next_reg_rdata[sap_pkg::SAP_ST_RATIO_LSB +: 4] = cfg.ratio;
          next_reg_rdata[sap_pkg::SAP_ST_MASTER] = master;
          next_reg_rdata[sap_pkg::SAP_ST_TDM] = tdm;
          next_reg_rdata[sap_pkg::SAP_ST_FIFO_EMPTY] = !fifo_out_valid;
        end
        sap_pkg::SAP_REG_PERIOD: begin
          next_reg_rdata[sap_pkg::SAP_PERIOD_W-1:0] = cfg.period;
        end
        default: begin
          next_reg_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= sap_pkg::SAP_CTRL_RESET;
      reg_rdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ---------------- sample fifo ----------------
  sap_pkg::sap_pair_s fifo_out_data;
  logic fifo_pop;

  sap_fifo #(
    .WIDTH($bits(sap_pkg::sap_pair_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(sample_in_valid),
    .in_ready(sample_in_ready),
    .in_data(sample_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ---------------- serializer ----------------
  logic [sap_pkg::SAP_FRAME_BITS-1:0] shreg, next_shreg;
  logic [sap_pkg::SAP_WORD_BITS-1:0] right_hold, next_right_hold;
  logic next_sdo;
  logic run;
  logic left_start, right_start;
  logic [sap_pkg::SAP_WORD_BITS-1:0] left_word, right_now;
  logic [sap_pkg::SAP_FRAME_BITS-1:0] load_val;

  assign run = port_en && cfg_ok;
  // i2s: left on frame sync fall, right on rise; tdm: both from the rise
  assign left_start = tdm ? fs_rise_ev : (fs_edge && !fs_cur);
  assign right_start = !tdm && fs_rise_ev;
  // an empty fifo at frame start pops nothing; the frame carries zeros
  assign fifo_pop = bclk_rise && left_start && run;
  assign left_word = (fifo_out_valid && left_en) ? fifo_out_data.left : '0;
  assign right_now = (fifo_out_valid && right_en) ? fifo_out_data.right : '0;

  // i2s word parked in the upper half with zeros behind it; tdm loads left over right
  always_comb begin
    if (tdm) begin
      load_val = {left_word, right_now};
    end else if (left_start) begin
      load_val = {left_word, {sap_pkg::SAP_WORD_BITS{1'b0}}};
    end else begin
      load_val = {right_hold, {sap_pkg::SAP_WORD_BITS{1'b0}}};
    end
  end

  // load at frame sync detect, shift out on the chosen edge
  always_comb begin
    next_shreg = shreg;
    next_right_hold = right_hold;
    next_sdo = serial_data_output;
    if (!run) begin
      next_shreg = '0;
      next_sdo = 1'b0;
    end else if (bclk_rise && (left_start || right_start)) begin
      if (tdm) begin
        // tdm sends its MSB on the detecting rising edge
        next_sdo = load_val[sap_pkg::SAP_FRAME_BITS-1];
        next_shreg = {load_val[sap_pkg::SAP_FRAME_BITS-2:0], 1'b0};
      end else begin
        next_shreg = load_val;
      end
      if (left_start) begin
        next_right_hold = right_now;
      end
    end else if (tdm ? bclk_rise : bclk_fall) begin
      next_sdo = shreg[sap_pkg::SAP_FRAME_BITS-1];
      next_shreg = {shreg[sap_pkg::SAP_FRAME_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shreg <= '0;
      right_hold <= '0;
      serial_data_output <= 1'b0;
    end else begin
      shreg <= next_shreg;
      right_hold <= next_right_hold;
      serial_data_output <= next_sdo;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/sap_rate_detect.sv
// frame rate and bit-clock ratio detection for automatic clock setup
`timescale 1ns/10ps
`default_nettype none
module sap_rate_detect (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bclk_rise,
  input wire logic fs_rise,
  output sap_pkg::sap_cfg_s cfg
);
  logic [sap_pkg::SAP_PERIOD_W-1:0] clk_cnt, next_clk_cnt;
  logic [sap_pkg::SAP_BCNT_W-1:0] bclk_cnt, next_bclk_cnt;
  sap_pkg::sap_cfg_s next_cfg;
  logic [4:0] rate_hit;
  logic [4:0] ratio_hit;

  // returns {hit, fam44, idx} for a measured frame period
  function automatic logic [4:0] find_rate(input logic [sap_pkg::SAP_PERIOD_W-1:0] p);
    int nom;
    int diff;
    find_rate = '0;
    for (int i = 0; i < sap_pkg::SAP_NUM_RATES; i++) begin
      nom = sap_pkg::SAP_CLK_HZ / sap_pkg::SAP_RATE48_HZ[i];
      diff = int'(p) - nom;
      if ((diff < 0 ? -diff : diff) <= (nom >>> sap_pkg::SAP_TOL_SHIFT)) begin
        find_rate = {1'b1, 1'b0, 3'(i)};
      end
      nom = sap_pkg::SAP_CLK_HZ / sap_pkg::SAP_RATE44_HZ[i];
      diff = int'(p) - nom;
      if ((diff < 0 ? -diff : diff) <= (nom >>> sap_pkg::SAP_TOL_SHIFT)) begin
        find_rate = {1'b1, 1'b1, 3'(i)};
      end
    end
  endfunction

  // returns {hit, idx} for a bit-clock count per frame
  function automatic logic [4:0] find_ratio(input logic [sap_pkg::SAP_BCNT_W-1:0] c);
    find_ratio = '0;
    for (int i = 0; i < sap_pkg::SAP_NUM_RATIOS; i++) begin
      if (int'(c) == sap_pkg::SAP_RATIOS[i]) begin
        find_ratio = {1'b1, 4'(i)};
      end
    end
  endfunction

  // reserved cells of the two rate tables
  function automatic logic supported(input logic fam44, input logic [2:0] r, input logic [3:0] q);
    supported = 1'b1;
    if (r == sap_pkg::SAP_RIDX_QUAD && q >= sap_pkg::SAP_QIDX_192) supported = 1'b0;
    if (r == sap_pkg::SAP_RIDX_DOUBLE && q >= sap_pkg::SAP_QIDX_384) supported = 1'b0;
    if (r == sap_pkg::SAP_RIDX_LOWEST && q <= (fam44 ? sap_pkg::SAP_QIDX_32 : sap_pkg::SAP_QIDX_24)) begin
      supported = 1'b0;
    end
    if (fam44 && r == sap_pkg::SAP_RIDX_SECOND && q < sap_pkg::SAP_QIDX_24) supported = 1'b0;
  endfunction

  assign rate_hit = find_rate(clk_cnt);
  assign ratio_hit = find_ratio(bclk_cnt);

  // count clk and bit clocks per frame, judge at each frame start
  always_comb begin
    next_clk_cnt = (&clk_cnt) ? clk_cnt : clk_cnt + 1'b1;
    next_bclk_cnt = (&bclk_cnt) ? bclk_cnt : bclk_cnt + (bclk_rise ? 1'b1 : 1'b0);
    next_cfg = cfg;
    if (fs_rise) begin
      next_clk_cnt = '0;
      // the detecting rise is the first bit clock of the new frame
      next_bclk_cnt = {{(sap_pkg::SAP_BCNT_W-1){1'b0}}, 1'b1};
      next_cfg.period = clk_cnt;
      next_cfg.fam44 = rate_hit[3];
      next_cfg.rate = rate_hit[2:0];
      next_cfg.ratio = ratio_hit[3:0];
      next_cfg.valid = rate_hit[4] && ratio_hit[4] && supported(rate_hit[3], rate_hit[2:0], ratio_hit[3:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_cnt <= '0;
      bclk_cnt <= '0;
      cfg <= '0;
    end else begin
      clk_cnt <= next_clk_cnt;
      bclk_cnt <= next_bclk_cnt;
      cfg <= next_cfg;
    end
  end
endmodule
`default_nettype wire
